/* File: src/acs_mux_clock.sv */
// What this block does
// - the conversion clock comes from the internal fast RC oscillator when the source bit is 1, else from the bus clock.
// - from the bus clock the conversion clock period is two bus periods times divider plus one.
// - the divider is ignored while the RC oscillator is selected.
// - the auto-sample time applies only when the trigger source is 111.
// - sample B negative input is analog input 1 when its bit is 1, else the low reference.
// - sample B positive code 0-12 selects an analog input, 13 temperature sensor, 14 internal reference, 15 open.
// - sample A negative input is analog input 1 when its bit is 1, else the low reference.
// - sample A positive code uses the same table as sample B.
// - unimplemented bits of all three configuration registers read as zero.
// - on the small package inputs 6 to 8 and 12 are absent; input 12 exists only on the large one.
// - with alternate off sample A is always used, else A first then B and A in turn.
// - offset calibration ties both inputs to the low reference, overriding selection.
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_mux_clock
    import acs_pkg::*;
#(
    parameter acs_pkg_size_t PKG_SIZE = ACS_PKG_LARGE,
    parameter int            NUM_AIN  = 13
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // fast rc oscillator tick and converter sequencing
    input  wire logic        frc_tick,
    input  wire logic        sample_start,
    input  wire logic        conv_done,
    // conversion clock and sample timing
    output logic             conv_clk_tick,
    output logic             samp_time_valid,
    output logic [4:0]       samp_time,
    // sample-and-hold connection
    output logic [15:0]      sh_pos_onehot,
    output logic             sh_neg_ain1,
    output logic             sh_neg_low_reference,
    output logic             sh_pos_low_reference,
    output logic             sh_using_b
);
    // the decode table serves exactly thirteen analog inputs and three package sizes
    if (NUM_AIN != 13) begin : g_bad_ain
        $error("acs_mux_clock: NUM_AIN must be 13");
    end
    if (PKG_SIZE != ACS_PKG_SMALL && PKG_SIZE != ACS_PKG_MEDIUM &&
        PKG_SIZE != ACS_PKG_LARGE) begin : g_bad_pkg
        $error("acs_mux_clock: PKG_SIZE has no input mask");
    end

    logic [31:0] clkctl_r;
    logic [31:0] insel_r;
    logic [31:0] ctrl_r;
    logic        aw_held_r;
    logic        w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic [8:0]  div_cnt_r;
    logic        conv_tick_r;
    acs_phase_t  phase_r;
    logic        next_b_r;
    logic [15:0] pos_r;
    logic        neg_ain1_r;
    logic        neg_low_reference_r;
    logic        pos_low_reference_r;
    logic        using_b_r;
    logic [4:0]  samp_time_r;
    logic        samp_valid_r;

    // four-bit selection code to onehot, with package-absent inputs dropped
    function automatic logic [15:0] acs_decode(input logic [3:0] code);
        logic [15:0] oh;
        oh = 16'h0001 << code;
        if (PKG_SIZE == ACS_PKG_SMALL) begin
            oh = oh & 16'hee3f;
        end else if (PKG_SIZE == ACS_PKG_MEDIUM) begin
            oh = oh & 16'hefff;
        end
        return oh;
    endfunction

    // byte-lane merge; the mask keeps unimplemented bits at zero
    function automatic logic [31:0] acs_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s, input logic [31:0] m);
        logic [31:0] bm;
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return ((old & ~bm) | (d & bm)) & m;
    endfunction

    // byte offset to word index, compared against address bits 11:2
    function automatic logic [9:0] acs_index(input logic [11:0] off);
        return off[11:2];
    endfunction

    // the four word addresses that the block answers
    function automatic logic acs_mapped(input logic [9:0] idx);
        return idx == acs_index(`ACS_OFF_CLKCTL) || idx == acs_index(`ACS_OFF_INSEL) ||
               idx == acs_index(`ACS_OFF_CTRL) || idx == acs_index(`ACS_OFF_STATUS);
    endfunction

    // write channel: address and data taken in either order
    wire        aw_have   = aw_held_r | s_axi_awvalid;
    wire        w_have    = w_held_r | s_axi_wvalid;
    // no new write is taken until the previous response has gone
    wire        wr_fire   = aw_have & w_have & ~s_axi_bvalid;
    wire [11:0] wr_addr   = aw_held_r ? awaddr_r : s_axi_awaddr;
    wire [31:0] wr_data   = w_held_r ? wdata_r : s_axi_wdata;
    wire [3:0]  wr_strb   = w_held_r ? wstrb_r : s_axi_wstrb;
    wire        wr_hit    = acs_mapped(wr_addr[11:2]);
    wire        wr_clk    = wr_fire && wr_addr[11:2] == acs_index(`ACS_OFF_CLKCTL);
    wire        wr_sel    = wr_fire && wr_addr[11:2] == acs_index(`ACS_OFF_INSEL);
    wire        wr_ctl    = wr_fire && wr_addr[11:2] == acs_index(`ACS_OFF_CTRL);
    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;

    // read channel
    wire        rd_fire   = s_axi_arvalid & s_axi_arready;
    wire [9:0]  rd_idx    = s_axi_araddr[11:2];
    // status: bit 18 setting b, bits 17:2 positive onehot, bits 1:0 phase
    wire [31:0] status_w  = {13'h0000, sh_using_b, pos_r, phase_r};
    wire        rd_hit    = acs_mapped(rd_idx);
    wire [31:0] rd_val    = (rd_idx == acs_index(`ACS_OFF_CLKCTL)) ? clkctl_r :
                            (rd_idx == acs_index(`ACS_OFF_INSEL))  ? insel_r :
                            (rd_idx == acs_index(`ACS_OFF_CTRL))   ? ctrl_r :
                            (rd_idx == acs_index(`ACS_OFF_STATUS)) ? status_w : 32'h0000_0000;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            awaddr_r     <= 12'h000;
            wdata_r      <= 32'h0000_0000;
            wstrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
            clkctl_r     <= `ACS_CLKCTL_RST;
            insel_r      <= `ACS_INSEL_RST;
            ctrl_r       <= `ACS_CTRL_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? 2'h0 : 2'h3;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // masks keep unimplemented bits at zero
            if (wr_clk) begin
                clkctl_r <= acs_merge(clkctl_r, wr_data, wr_strb, `ACS_CLKCTL_MASK);
            end
            if (wr_sel) begin
                insel_r <= acs_merge(insel_r, wr_data, wr_strb, `ACS_INSEL_MASK);
            end
            if (wr_ctl) begin
                ctrl_r <= acs_merge(ctrl_r, wr_data, wr_strb, `ACS_CTRL_MASK);
            end
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_hit ? 2'h0 : 2'h3;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // conversion clock
    wire       src_frc   = clkctl_r[`ACS_CLK_SRC_BIT];
    wire [7:0] divider   = clkctl_r[`ACS_DIV_LSB +: 8];
    // a tick every 2*(div+1) bus cycles; divider unused on rc source
    wire       div_wrap  = div_cnt_r >= {divider, 1'b1};
    wire [8:0] div_nxt   = (src_frc || div_wrap) ? 9'h000 : div_cnt_r + 9'h001;
    wire       tick_nxt  = src_frc ? frc_tick : div_wrap;

    // alternation and calibration overrides
    wire [2:0] trig_src  = ctrl_r[`ACS_TRIG_LSB +: 3];
    wire [4:0] samt_field = clkctl_r[`ACS_SAMT_LSB +: 5];
    wire       alt_en    = ctrl_r[`ACS_ALT_BIT];
    wire       offset_cal_mode    = ctrl_r[`ACS_OFFSET_CAL_MODE_BIT];
    wire       use_b     = alt_en & next_b_r;
    wire [3:0] pos_code  = use_b ? insel_r[`ACS_POSB_LSB +: 4] : insel_r[`ACS_POSA_LSB +: 4];
    wire       neg_sel   = use_b ? insel_r[`ACS_NEGB_BIT] : insel_r[`ACS_NEGA_BIT];
    // a new sampling phase starts on a rise out of idle or conversion
    wire       take      = sample_start && phase_r != ACS_SAMPLE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_r    <= 9'h000;
            conv_tick_r  <= 1'b0;
            phase_r      <= ACS_IDLE;
            next_b_r     <= 1'b0;
            pos_r        <= 16'h0000;
            neg_ain1_r   <= 1'b0;
            neg_low_reference_r  <= 1'b1;
            pos_low_reference_r  <= 1'b0;
            using_b_r    <= 1'b0;
            samp_time_r  <= 5'h00;
            samp_valid_r <= 1'b0;
        end else begin
            div_cnt_r    <= div_nxt;
            conv_tick_r  <= tick_nxt;
            samp_valid_r <= trig_src == `ACS_TRIG_AUTO;
            samp_time_r  <= (trig_src == `ACS_TRIG_AUTO) ? samt_field : 5'h00;
            if (!alt_en) begin
                next_b_r <= 1'b0;
            end
            // setting latched at sampling start, held to end of conversion
            if (take) begin
                pos_r       <= offset_cal_mode ? 16'h0000 : acs_decode(pos_code);
                pos_low_reference_r <= offset_cal_mode;
                neg_ain1_r  <= ~offset_cal_mode & neg_sel;
                neg_low_reference_r <= offset_cal_mode | ~neg_sel;
                using_b_r   <= use_b;
                next_b_r    <= alt_en & ~next_b_r;
            end
            case (phase_r)
                ACS_IDLE: begin
                    if (sample_start) begin
                        phase_r <= ACS_SAMPLE;
                    end
                end
                ACS_SAMPLE: begin
                    if (!sample_start) begin
                        phase_r <= ACS_CONV;
                    end
                end
                ACS_CONV: begin
                    if (sample_start) begin
                        phase_r <= ACS_SAMPLE;
                    end else if (conv_done) begin
                        phase_r <= ACS_IDLE;
                    end
                end
                default: begin
                    phase_r <= ACS_IDLE;
                end
            endcase
        end
    end

    assign conv_clk_tick   = conv_tick_r;
    assign samp_time       = samp_time_r;
    assign samp_time_valid = samp_valid_r;
    assign sh_pos_onehot   = pos_r;
    assign sh_neg_ain1     = neg_ain1_r;
    assign sh_neg_low_reference    = neg_low_reference_r;
    assign sh_pos_low_reference    = pos_low_reference_r;
    assign sh_using_b      = using_b_r;

    a_frc_tick_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        src_frc && $past(src_frc) |-> conv_clk_tick == $past(frc_tick))
        else $error("rc source tick does not follow oscillator");
    a_div_zero_period: assert property (@(posedge aclk) disable iff (!aresetn)
        $stable(clkctl_r) && !src_frc && divider == 8'h00 && conv_clk_tick
        && $past(clkctl_r) == clkctl_r ##1 $stable(clkctl_r) |=> conv_clk_tick)
        else $error("divider zero does not give two-cycle period");
    a_div_one_gap: assert property (@(posedge aclk) disable iff (!aresetn)
        !src_frc && divider == 8'h01 && $rose(conv_clk_tick) && $stable(clkctl_r)
        ##1 $stable(clkctl_r) |-> !conv_clk_tick)
        else $error("divider one ticks too early");
    a_frc_ignore_div: assert property (@(posedge aclk) disable iff (!aresetn)
        src_frc |=> div_cnt_r == 9'h000)
        else $error("divider runs on rc source");
    a_samp_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        trig_src != `ACS_TRIG_AUTO |=> !samp_time_valid && samp_time == 5'h00)
        else $error("sample time applied without auto trigger");
    a_neg_select: assert property (@(posedge aclk) disable iff (!aresetn)
        take && !offset_cal_mode |=> sh_neg_ain1 == $past(neg_sel) && sh_neg_low_reference != sh_neg_ain1)
        else $error("negative input not as selected");
    a_pos_decode: assert property (@(posedge aclk) disable iff (!aresetn)
        take && !offset_cal_mode && pos_code == 4'hf |=> sh_pos_onehot[15] && $countones(sh_pos_onehot) == 1)
        else $error("open code not decoded");
    a_small_absent: assert property (@(posedge aclk) disable iff (!aresetn)
        PKG_SIZE != ACS_PKG_LARGE |-> !sh_pos_onehot[12])
        else $error("input 12 present on smaller package");
    a_alt_order: assert property (@(posedge aclk) disable iff (!aresetn)
        take && !alt_en |=> !sh_using_b)
        else $error("sample b used with alternation off");
    a_cal_override: assert property (@(posedge aclk) disable iff (!aresetn)
        take && offset_cal_mode |=> sh_pos_low_reference && sh_neg_low_reference && sh_pos_onehot == 16'h0000)
        else $error("calibration does not tie inputs low");
    a_hold_setting: assert property (@(posedge aclk) disable iff (!aresetn)
        phase_r == ACS_CONV && !sample_start |=> $stable(sh_pos_onehot))
        else $error("setting changed during conversion");
    a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (clkctl_r & ~`ACS_CLKCTL_MASK) == 32'h0 && (insel_r & ~`ACS_INSEL_MASK) == 32'h0)
        else $error("unimplemented bits set");

    // outputs and bus answers, one edge after their cause or held on every edge
    a_tick_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
        !src_frc && conv_clk_tick |=> !conv_clk_tick)
        else $error("bus clock tick longer than one cycle");
    a_samp_apply: assert property (@(posedge aclk) disable iff (!aresetn)
        trig_src == `ACS_TRIG_AUTO |=> samp_time_valid && samp_time == $past(samt_field))
        else $error("sample time not applied with auto trigger");
    a_neg_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
        sh_neg_ain1 != sh_neg_low_reference)
        else $error("negative input not exactly one source");
    a_onehot_single: assert property (@(posedge aclk) disable iff (!aresetn)
        $countones(sh_pos_onehot) <= 1)
        else $error("more than one positive input selected");
    a_conv_hold_neg: assert property (@(posedge aclk) disable iff (!aresetn)
        phase_r == ACS_CONV && !sample_start |=> $stable(sh_neg_ain1) && $stable(sh_using_b))
        else $error("negative or b setting changed during conversion");
    a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && !rd_hit |=> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == 2'h3)
        else $error("unmapped read not answered with decode error");
    a_unmapped_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && !wr_hit |=> s_axi_bresp == 2'h3)
        else $error("unmapped write not answered with decode error");
endmodule
`default_nettype wire

/* File: src/acs_regs.svh */
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
// register byte offsets
`define ACS_OFF_CLKCTL     12'h000
`define ACS_OFF_INSEL      12'h004
`define ACS_OFF_CTRL       12'h008
`define ACS_OFF_STATUS     12'h00c
// clock control fields
`define ACS_CLK_SRC_BIT    15
`define ACS_SAMT_LSB       8
`define ACS_DIV_LSB        0
`define ACS_CLKCTL_MASK    32'h0000_9fff
// input select fields
`define ACS_NEGB_BIT       31
`define ACS_POSB_LSB       24
`define ACS_NEGA_BIT       23
`define ACS_POSA_LSB       16
`define ACS_INSEL_MASK     32'h8f8f_0000
// control fields
`define ACS_ALT_BIT        0
`define ACS_OFFSET_CAL_MODE_BIT     1
`define ACS_TRIG_LSB       4
`define ACS_CTRL_MASK      32'h0000_0073
// reset values
`define ACS_CLKCTL_RST     32'h0000_0000
`define ACS_INSEL_RST      32'h0000_0000
`define ACS_CTRL_RST       32'h0000_0000
// auto trigger code
`define ACS_TRIG_AUTO      3'h7
`endif

/* File: src/acs_pkg.sv */
package acs_pkg;
    typedef enum logic [1:0] {
        ACS_IDLE   = 2'b00,
        ACS_SAMPLE = 2'b01,
        ACS_CONV   = 2'b10
    } acs_phase_t;
    typedef enum logic [1:0] {
        ACS_PKG_SMALL  = 2'b00,
        ACS_PKG_MEDIUM = 2'b01,
        ACS_PKG_LARGE  = 2'b10
    } acs_pkg_size_t;
endpackage

/* File: testbench/acs_mux_clock_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_mux_clock_bench;
    import acs_pkg::*;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wr;
        logic [31:0] rd;
    } acs_row_t;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, frc_tick, sample_start, conv_done;
    logic        conv_clk_tick, samp_time_valid, sh_neg_ain1, sh_neg_low_reference, sh_pos_low_reference;
    logic        sh_using_b;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic [4:0]  samp_time;
    logic [15:0] sh_pos_onehot;
    int          bad_count, total_checks, gap, n;
    int          divs [3] = '{0, 1, 7};
    // unimplemented bits must come back as zero
    acs_row_t    rows [6] = '{
        '{`ACS_OFF_CLKCTL, 32'hffff_ffff, 32'h0000_9fff},
        '{`ACS_OFF_INSEL,  32'hffff_ffff, 32'h8f8f_0000},
        '{`ACS_OFF_CTRL,   32'hffff_ffff, 32'h0000_0073},
        '{`ACS_OFF_CLKCTL, 32'h0000_0000, 32'h0000_0000},
        '{`ACS_OFF_INSEL,  32'h0000_0000, 32'h0000_0000},
        '{`ACS_OFF_CTRL,   32'h0000_0000, 32'h0000_0000}};

    acs_mux_clock #(.PKG_SIZE(ACS_PKG_LARGE), .NUM_AIN(13)) i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frc_tick(frc_tick),
        .sample_start(sample_start), .conv_done(conv_done),
        .conv_clk_tick(conv_clk_tick), .samp_time_valid(samp_time_valid),
        .samp_time(samp_time), .sh_pos_onehot(sh_pos_onehot), .sh_neg_ain1(sh_neg_ain1),
        .sh_neg_low_reference(sh_neg_low_reference), .sh_pos_low_reference(sh_pos_low_reference), .sh_using_b(sh_using_b));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task hang(input string what);
        bad_count++;
        $display("CHECK FAILED at %0t: %s timed out", $time, what);
        print_verdict();
    endtask

    // address and data offered together, each dropped once taken
    task axi_write(input logic [11:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40 && !(aw_done && w_done); n++) begin
            @(posedge aclk);
            if (awready && !aw_done) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_done) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        if (!(aw_done && w_done)) hang("write address");
        for (n = 0; n < 40 && bvalid !== 1'b1; n++) @(posedge aclk);
        if (n == 40) hang("write");
        resp = bresp;
        bready <= 1'b0;
    endtask

    task axi_read(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arready === 1'b1) break;
        end
        if (n == 40) hang("read address");
        arvalid <= 1'b0;
        for (n = 0; n < 40 && rvalid !== 1'b1; n++) @(posedge aclk);
        if (n == 40) hang("read");
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // one sampling phase followed by a conversion
    task sample_once(input logic [15:0] pos, input logic neg1, input logic use_b,
                     input logic cal);
        @(posedge aclk);
        sample_start <= 1'b1;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        check(sh_pos_onehot, cal ? 16'h0000 : pos, "positive select");
        check(sh_neg_ain1, neg1 & !cal, "negative ain1");
        check(sh_neg_low_reference, !neg1 | cal, "negative low ref");
        check(sh_pos_low_reference, cal, "positive low ref");
        check(sh_using_b, use_b, "setting b in use");
        @(posedge aclk);
        sample_start <= 1'b0;
        @(posedge aclk);
        conv_done <= 1'b1;
        @(posedge aclk);
        conv_done <= 1'b0;
        @(negedge aclk);
        check(sh_pos_onehot, cal ? 16'h0000 : pos, "held through conversion");
    endtask

    // first edge seen may be stale after a divider change, so callers measure twice
    task tick_gap(output int g);
        for (n = 0; n < 600 && !conv_clk_tick; n++) @(negedge aclk);
        if (n == 600) hang("tick");
        g = 0;
        do begin
            @(negedge aclk);
            g++;
        end while (!conv_clk_tick && g < 600);
    endtask

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, frc_tick, sample_start, conv_done} = '0;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0000_0000;
        wstrb = 4'hf;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            axi_write(rows[i].addr, rows[i].wr);
            axi_read(rows[i].addr);
            check(rd, rows[i].rd, "register readback");
        end
        foreach (divs[i]) begin
            axi_write(`ACS_OFF_CLKCTL, divs[i]);
            tick_gap(gap);
            tick_gap(gap);
            check(gap, 2 * (divs[i] + 1), "bus clock divider");
        end
        // rc source with a large divider: no ticks without the oscillator
        axi_write(`ACS_OFF_CLKCTL, 32'h0000_8007);
        repeat (2) @(posedge aclk);
        gap = 0;
        repeat (30) begin
            @(negedge aclk);
            gap += conv_clk_tick;
        end
        check(gap, 0, "divider ignored");
        @(posedge aclk);
        frc_tick <= 1'b1;
        @(posedge aclk);
        frc_tick <= 1'b0;
        gap = 0;
        repeat (4) begin
            @(negedge aclk);
            gap += conv_clk_tick;
        end
        check(gap, 1, "rc oscillator tick");
        axi_write(`ACS_OFF_CTRL, 32'h0000_0070);
        axi_write(`ACS_OFF_CLKCTL, 32'h0000_1f00);
        repeat (2) @(negedge aclk);
        check(samp_time, 5'h1f, "auto trigger sample time");
        check(samp_time_valid, 1'b1, "auto trigger sample valid");
        axi_write(`ACS_OFF_CTRL, 32'h0000_0060);
        repeat (2) @(negedge aclk);
        check(samp_time, 5'h00, "other trigger sample time");
        check(samp_time_valid, 1'b0, "other trigger sample valid");
        axi_write(`ACS_OFF_CTRL, 32'h0000_0000);
        // code 15 stands for the open input here
        for (int c = 0; c < 16; c++) begin
            axi_write(`ACS_OFF_INSEL, {8'h00, c[0], 3'b000, c[3:0], 16'h0000});
            sample_once(16'h0001 << c, c[0], 1'b0, 1'b0);
        end
        axi_write(`ACS_OFF_CTRL, 32'h0000_0001);
        for (int c = 0; c < 16; c++) begin
            axi_write(`ACS_OFF_INSEL, {c[0], 3'b000, c[3:0], 24'h00_0000});
            sample_once(16'h0001, 1'b0, 1'b0, 1'b0);
            sample_once(16'h0001 << c, c[0], 1'b1, 1'b0);
        end
        axi_write(`ACS_OFF_INSEL, 32'h0085_0000);
        axi_write(`ACS_OFF_CTRL, 32'h0000_0002);
        sample_once(16'h0020, 1'b1, 1'b0, 1'b1);
        axi_write(`ACS_OFF_CTRL, 32'h0000_0000);
        sample_once(16'h0020, 1'b1, 1'b0, 1'b0);
        axi_write(12'h010, 32'hffff_ffff);
        check(resp, 2'b11, "unmapped write response");
        axi_read(12'h010);
        check(resp, 2'b11, "unmapped read response");
        check(rd, 32'h0000_0000, "unmapped read data");
        // reset in mid-run must clear what was written
        axi_write(`ACS_OFF_CLKCTL, 32'h0000_9fff);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`ACS_OFF_CLKCTL);
        check(rd, 32'h0000_0000, "clock control after reset");
        axi_read(`ACS_OFF_INSEL);
        check(rd, 32'h0000_0000, "input select after reset");
        axi_read(`ACS_OFF_STATUS);
        check(rd, 32'h0000_0000, "status after reset");
        check(sh_neg_low_reference, 1'b1, "low ref after reset");
        print_verdict();
    end
endmodule
`default_nettype wire
